/* ddt_pkg.sv */
package ddt_pkg;
  localparam int DESC_LEN = 7;
  localparam int TAP_A = 4;
  localparam int TAP_B = 7;
  localparam int CHIPS = 8;
  localparam logic [5:0] LAST_IDX_HIGH = 6'h3F;
  localparam logic [5:0] LAST_IDX_LOW = 6'h07;
  localparam logic [2:0] FILL_SYMS = 3'h7;
  localparam logic [2:0] BITS_HIGH_LAST = 3'h7;
  localparam logic [2:0] BITS_LOW_LAST = 3'h3;
  localparam logic signed [7:0] TIMING_LIMIT = 8'sh48;
  localparam int COEF_SHIFT = 4;
  localparam int KP_SHIFT = 2;
  localparam int KI_SHIFT = 6;
  localparam int SLAVE_SHIFT = 4;
  localparam logic signed [15:0] SLAVE_WRAP = 16'sh0400;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_COLLECT = 4'b0010,
    ST_CORR = 4'b0100,
    ST_SHIFT = 4'b1000
  } ddt_state_t;
endpackage : ddt_pkg

/* ddt_descrambler.sv */
`timescale 1ns/100ps
module ddt_descrambler
  import ddt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic inBit,
  input wire logic inValid,
  output logic outBit,
  output logic outValid
);
  typedef struct packed {
    logic [DESC_LEN-1:0] sr;
    logic outBit;
    logic outValid;
  } ddt_desc_t;
  ddt_desc_t s, next_s;

  // multiply by the polynomial: register holds received bits
  always_comb begin
    next_s = s;
    next_s.outValid = inValid;
    if (inValid) begin
      next_s.outBit = inBit ^ s.sr[TAP_A-1] ^ s.sr[TAP_B-1];
      next_s.sr = {s.sr[DESC_LEN-2:0], inBit};
    end
    if (clear) begin
      next_s.sr = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign outBit = s.outBit;
  assign outValid = s.outValid;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  desc_output_a: assert property (
    inValid |=> outValid && outBit == ($past(inBit)
      ^ $past(s.sr[TAP_A-1]) ^ $past(s.sr[TAP_B-1])))
    else $error("descrambler output wrong");
  desc_shift_a: assert property (
    inValid && !clear ##1 inValid && !clear |=> s.sr[1] == $past(inBit, 2))
    else $error("descrambler register not shifting");
endmodule : ddt_descrambler

/* ddt_picker.sv */
`timescale 1ns/100ps
module ddt_picker
  import ddt_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic candValid,
  input wire logic signed [WIDTH-1:0] candVal,
  input wire logic [6:0] candIdx,
  output logic [6:0] bestIdx,
  output logic bestNeg,
  output logic [WIDTH-1:0] bestMag
);
  typedef struct packed {
    logic [6:0] idx;
    logic neg;
    logic [WIDTH-1:0] mag;
  } ddt_pick_t;
  ddt_pick_t s, next_s;
  logic [WIDTH-1:0] candMag;

  // first of equal magnitudes is kept, ties never move the pick
  always_comb begin
    next_s = s;
    candMag = candVal[WIDTH-1] ? WIDTH'(-candVal) : candVal;
    if (start) begin
      next_s = '0;
    end
    if (candValid && (start || candMag > s.mag)) begin
      next_s.idx = candIdx;
      next_s.neg = candVal[WIDTH-1];
      next_s.mag = candMag;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bestIdx = s.idx;
  assign bestNeg = s.neg;
  assign bestMag = s.mag;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  pick_bigger_a: assert property (
    candValid && !start && candMag > s.mag
      |=> bestIdx == $past(candIdx) && bestMag == $past(candMag))
    else $error("picker missed a larger candidate");
endmodule : ddt_picker

/* ddt_cck_demod.sv */
`timescale 1ns/100ps
module ddt_cck_demod
  import ddt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic signed [5:0] adcI,
  input wire logic signed [5:0] adcQ,
  input wire logic adcValid,
  input wire logic headerLastBit,
  input wire logic packetEnd,
  input wire logic rateHigh,
  input wire logic trainValid,
  input wire logic [3:0] trainIci,
  input wire logic [3:0] trainIsi,
  input wire logic eqIciDisable,
  input wire logic eqIsiDisable,
  input wire logic lockTrackEnable,
  input wire logic svcLockLocal,
  input wire logic rxSvcLock,
  output logic rxBit,
  output logic rxBitValid,
  output logic signed [7:0] timingAdjust
);
  typedef struct packed {
    logic signed [5:0] s1I, s1Q, s2I, s2Q;
    logic s1V, s2V;
    ddt_state_t st;
    logic [CHIPS-1:0][7:0] chI, chQ;
    logic [2:0] chipCnt, bitCnt, fillCnt;
    logic [5:0] corrIdx;
    logic [7:0] symBits;
    logic [1:0] refQuad;
    logic load, decim, prevSign, pickStart;
    logic signed [7:0] midI, isiResid, timing;
    logic signed [15:0] ncoPhase, loopInteg, slaveAcc, elAcc;
    logic [3:0] coefIci, coefIsi;
    logic dsIn, dsInValid, dsClear, rxBit, rxBitValid, dsFill, fillOk;
  } ddt_main_t;
  ddt_main_t s, next_s;

  logic signed [7:0] dI, dQ;
  logic signed [10:0] corrI, corrQ;
  logic signed [15:0] iciI, iciQ, candVal;
  logic [6:0] candIdx, bestIdx;
  logic candValid, bestNeg, chipTick, midTick, trans, lockMode, lastIdx;
  logic signed [9:0] err;
  logic [1:0] dibit;
  logic [15:0] bestMag;
  logic dsBit, dsValid;

  ////////////////////////////////////////////////////////////////////
  // rotate back by the oscillator quadrant
  function automatic logic [15:0] derot(input logic signed [5:0] i,
      input logic signed [5:0] q, input logic [1:0] quad);
    logic signed [7:0] xi, xq;
    xi = 8'(i);
    xq = 8'(q);
    unique case (quad)
      2'h0: derot = {xi, xq};
      2'h1: derot = {xq, 8'(-xi)};
      2'h2: derot = {8'(-xi), 8'(-xq)};
      2'h3: derot = {8'(-xq), xi};
    endcase
  endfunction : derot

  // one code of the bank: sign per chip from the index bits
  function automatic logic signed [10:0] corr(
      input logic [CHIPS-1:0][7:0] ch, input logic [5:0] k);
    logic signed [10:0] acc;
    acc = '0;
    for (int c = 0; c < CHIPS; c++) begin
      if (^{k[5:3] & 3'(c), k[2:0] & ~3'(c)}) begin
        acc = acc - 11'(signed'(ch[c]));
      end else begin
        acc = acc + 11'(signed'(ch[c]));
      end
    end
    corr = acc;
  endfunction : corr

  // inter-chip correction scales out a trained leakage share
  function automatic logic signed [15:0] iciFix(
      input logic signed [10:0] v, input logic [3:0] coef,
      input logic off);
    logic signed [15:0] w;
    w = 16'(v);
    iciFix = off ? w : 16'(w - ((w * signed'({1'b0, coef})) >>> COEF_SHIFT));
  endfunction : iciFix

  // phase change quadrant to dibit, first bit in time on the left
  function automatic logic [1:0] dqpskDibit(input logic [1:0] d);
    unique case (d)
      2'h0: dqpskDibit = 2'b00;
      2'h1: dqpskDibit = 2'b01;
      2'h2: dqpskDibit = 2'b11;
      2'h3: dqpskDibit = 2'b10;
    endcase
  endfunction : dqpskDibit

  ////////////////////////////////////////////////////////////////////
  // derotation, decimation and the shared datapath terms
  always_comb begin
    {dI, dQ} = derot(s.s2I, s.s2Q, s.ncoPhase[15:14]);
    chipTick = s.s2V && !s.decim;
    midTick = s.s2V && s.decim;
    trans = dI[7] != s.prevSign;
    err = (dI[7] ? -10'(dQ) : 10'(dQ)) - (dQ[7] ? -10'(dI) : 10'(dI));
    lockMode = lockTrackEnable && svcLockLocal && rxSvcLock;
    corrI = corr(s.chI, s.corrIdx);
    corrQ = corr(s.chQ, s.corrIdx);
    iciI = iciFix(corrI, s.coefIci, eqIciDisable);
    iciQ = iciFix(corrQ, s.coefIci, eqIciDisable);
    lastIdx = s.corrIdx == (rateHigh ? LAST_IDX_HIGH : LAST_IDX_LOW);
    candValid = s.st == ST_CORR;
    if (rateHigh && (iciQ[15] ? -iciQ : iciQ) > (iciI[15] ? -iciI : iciI)) begin
      candVal = iciQ;
      candIdx = {s.corrIdx, 1'b1};
    end else begin
      candVal = iciI; // lower rate looks at the eight I outputs only
      candIdx = {s.corrIdx, 1'b0};
    end
    dibit = dqpskDibit({bestNeg, bestIdx[0]} - s.refQuad);
  end

  ////////////////////////////////////////////////////////////////////
  // next state: sync, carrier loop, timing, symbol sequencing
  always_comb begin
    next_s = s;
    next_s.s1I = adcI;
    next_s.s1Q = adcQ;
    next_s.s1V = adcValid;
    next_s.s2I = s.s1I;
    next_s.s2Q = s.s1Q;
    next_s.s2V = s.s1V;
    next_s.pickStart = 1'b0;
    next_s.dsInValid = 1'b0;
    next_s.dsClear = 1'b0;
    next_s.rxBit = dsBit;
    // fill state travels with each bit, so the seventh symbol's tail
    // cannot slip out once the fill count has already moved on
    next_s.fillOk = s.dsFill;
    next_s.rxBitValid = dsValid && s.fillOk;
    if (s.s2V) begin
      next_s.decim = ~s.decim;
    end
    // lead/lag loop, oscillator always advances by the integrator
    next_s.ncoPhase = s.ncoPhase + (s.loopInteg >>> KI_SHIFT);
    if (chipTick) begin
      next_s.prevSign = dI[7];
      if (trans) begin
        next_s.loopInteg = s.loopInteg + 16'(err);
        next_s.ncoPhase = s.ncoPhase + (s.loopInteg >>> KI_SHIFT)
          + (16'(err) <<< KP_SHIFT);
        next_s.elAcc = s.elAcc + (s.prevSign ? -16'(s.midI) : 16'(s.midI));
      end
    end
    if (midTick) begin
      next_s.midI = dI;
    end
    unique case (s.st)
      ST_IDLE: begin
        if (headerLastBit) begin
          next_s.refQuad = {dI[7] ^ dQ[7] ? dQ[7] : dI[7],
            (dQ[7] ? -dQ : dQ) > (dI[7] ? -dI : dI)};
          next_s.st = ST_COLLECT;
          next_s.chipCnt = '0;
          next_s.fillCnt = '0;
          next_s.isiResid = '0;
          next_s.elAcc = '0;
          next_s.dsClear = 1'b1;
        end else if (trainValid) begin
          next_s.coefIci = trainIci;
          next_s.coefIsi = trainIsi;
        end
      end
      ST_COLLECT: begin
        if (chipTick) begin
          next_s.chI[s.chipCnt] = (s.chipCnt == 3'h0 && !eqIsiDisable)
            ? 8'(dI - s.isiResid) : dI;
          next_s.chQ[s.chipCnt] = dQ;
          next_s.chipCnt = s.chipCnt + 3'h1;
          if (s.chipCnt == 3'(CHIPS - 1)) begin
            next_s.st = ST_CORR;
            next_s.corrIdx = '0;
            next_s.pickStart = 1'b1;
            if (lockMode) begin
              // divide the carrier offset down into timing steps
              next_s.slaveAcc = s.slaveAcc + (s.loopInteg >>> SLAVE_SHIFT);
              if (next_s.slaveAcc >= SLAVE_WRAP) begin
                next_s.slaveAcc = next_s.slaveAcc - SLAVE_WRAP;
                next_s.timing = s.timing + 8'sh01;
              end else if (next_s.slaveAcc <= -SLAVE_WRAP) begin
                next_s.slaveAcc = next_s.slaveAcc + SLAVE_WRAP;
                next_s.timing = s.timing - 8'sh01;
              end
            end else if (s.elAcc != '0) begin
              next_s.timing = s.elAcc[15] ? s.timing - 8'sh01
                : s.timing + 8'sh01;
            end
            next_s.elAcc = '0;
            // hold at the ends, a wrap would jump a whole range
            if (next_s.timing > TIMING_LIMIT) begin
              next_s.timing = TIMING_LIMIT;
            end else if (next_s.timing < -TIMING_LIMIT) begin
              next_s.timing = -TIMING_LIMIT;
            end
          end
        end
      end
      ST_CORR: begin
        next_s.corrIdx = s.corrIdx + 6'h01;
        if (lastIdx) begin
          next_s.st = ST_SHIFT;
          next_s.load = 1'b1;
          next_s.bitCnt = '0;
        end
      end
      ST_SHIFT: begin
        if (s.load) begin
          next_s.load = 1'b0;
          next_s.symBits = rateHigh ? {bestIdx, dibit[1]}
            : {bestIdx[3:1], dibit[1], 4'h0};
          next_s.refQuad = {bestNeg, bestIdx[0]};
          next_s.isiResid = 8'((16'(bestMag) * 16'(s.coefIsi))
            >>> (COEF_SHIFT + 3));
        end else begin
          next_s.dsIn = s.symBits[7];
          next_s.dsInValid = 1'b1;
          next_s.dsFill = s.fillCnt == FILL_SYMS;
          next_s.symBits = {s.symBits[6:0], 1'b0};
          next_s.bitCnt = s.bitCnt + 3'h1;
          if (s.bitCnt == (rateHigh ? BITS_HIGH_LAST : BITS_LOW_LAST)) begin
            next_s.st = ST_COLLECT;
            next_s.chipCnt = '0;
            if (s.fillCnt != FILL_SYMS) begin
              next_s.fillCnt = s.fillCnt + 3'h1;
            end
          end
        end
      end
    endcase
    if (packetEnd) begin
      next_s.st = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.st <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // symbol picking and the bit stream descrambler
  ddt_picker #(.WIDTH(16)) picker (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(s.pickStart),
    .candValid(candValid),
    .candVal(candVal),
    .candIdx(candIdx),
    .bestIdx(bestIdx),
    .bestNeg(bestNeg),
    .bestMag(bestMag)
  );

  ddt_descrambler descrambler (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(s.dsClear),
    .inBit(s.dsIn),
    .inValid(s.dsInValid),
    .outBit(dsBit),
    .outValid(dsValid)
  );

  assign rxBit = s.rxBit;
  assign rxBitValid = s.rxBitValid;
  assign timingAdjust = s.timing;

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  timing_bound_a: assert property (
    s.timing <= TIMING_LIMIT && s.timing >= -TIMING_LIMIT)
    else $error("timing adjust left its range");
  fill_gate_a: assert property (
    rxBitValid |-> $past(s.fillCnt) == FILL_SYMS)
    else $error("data valid before descrambler filled");
  wait_header_a: assert property (
    s.st == ST_IDLE && !headerLastBit |=> s.st == ST_IDLE)
    else $error("demod left idle without header");
  coef_frozen_a: assert property (
    s.st != ST_IDLE |=> $stable(s.coefIci) && $stable(s.coefIsi))
    else $error("equalizer coefficients changed in packet");
  costas_gate_a: assert property (
    !(chipTick && trans) |=> $stable(s.loopInteg))
    else $error("carrier error updated without transition");
  ref_capture_a: assert property (
    s.st == ST_IDLE && headerLastBit && !packetEnd
      |=> s.st == ST_COLLECT && s.fillCnt == 3'h0)
    else $error("header end not taken as reference");
  corr_batch_a: assert property (
    s.st == ST_CORR && lastIdx |=> s.st == ST_SHIFT && s.load
      ##1 !s.load)
    else $error("symbol batch did not reach the picker");
  bits_low_a: assert property (
    s.st == ST_SHIFT && s.load && !rateHigh && !packetEnd
      |=> !s.dsInValid ##1 s.dsInValid [*4] ##1 !s.dsInValid)
    else $error("lower rate symbol not four bits");

  symbol_high_c: cover property (s.st == ST_SHIFT && s.load && rateHigh);
  symbol_low_c: cover property (s.st == ST_SHIFT && s.load && !rateHigh);
  timing_end_c: cover property (s.timing == TIMING_LIMIT);
  locked_c: cover property (lockMode && s.st == ST_CORR);
endmodule : ddt_cck_demod

/* ddt_front_end_model.sv */
`timescale 1ns/100ps
module ddt_front_end_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic symStart,
  output logic signed [5:0] adcI,
  output logic signed [5:0] adcQ,
  output logic adcValid,
  output logic busy
);
  logic [4:0] left;
  logic [7:0] seed;
  ////////////////////////////////////////////////////////////////////////////
  // one burst is 16 samples, two per chip, chip signs from a rolling seed
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      left <= 5'h00;
      seed <= 8'h5A;
      adcValid <= 1'b0;
      adcI <= 6'sh00;
      adcQ <= 6'sh00;
    end else if (left != 5'h00) begin
      left <= #1 left - 5'h01;
      adcValid <= #1 1'b1;
      adcI <= #1 seed[left[3:1]] ? 6'sh14 : 6'sh2C;
      adcQ <= #1 seed[~left[3:1]] ? 6'sh12 : 6'sh2E;
    end else begin
      // outside bursts the lines toggle so stale data never looks valid
      adcValid <= #1 1'b0;
      adcI <= #1 ~adcI;
      adcQ <= #1 ~adcQ;
      if (symStart) begin
        left <= #1 5'h10;
        seed <= #1 {seed[6:0], seed[7]} + 8'h03;
      end
    end
  end
  assign busy = (left != 5'h00);
endmodule : ddt_front_end_model

/* test_dsss_cck_demod_tracking.sv */
`timescale 1ns/100ps
module test_dsss_cck_demod_tracking;
  import ddt_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic symStart = 1'b0;
  logic headerLastBit = 1'b0;
  logic packetEnd = 1'b0;
  logic rateHigh = 1'b1;
  logic trainValid = 1'b0;
  logic [3:0] trainIci = 4'h0;
  logic [3:0] trainIsi = 4'h0;
  logic eqIciDisable = 1'b0;
  logic eqIsiDisable = 1'b0;
  logic lockTrackEnable = 1'b0;
  logic svcLockLocal = 1'b0;
  logic rxSvcLock = 1'b0;
  logic [6:0] refSr = 7'h00;
  logic [1:0] expHist = 2'h0;
  int descChecked = 0;
  logic signed [5:0] adcI;
  logic signed [5:0] adcQ;
  logic adcValid;
  logic busy;
  logic rxBit;
  logic rxBitValid;
  logic signed [7:0] timingAdjust;
  logic rangeBad = 1'b0;
  logic [15:0] bitCount = 16'h0000;
  int errors = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #20 sys_clk = ~sys_clk;
  ddt_front_end_model fe (.sys_clk(sys_clk), .reset_n(reset_n),
    .symStart(symStart), .adcI(adcI), .adcQ(adcQ), .adcValid(adcValid),
    .busy(busy));
  ddt_cck_demod dut (.sys_clk(sys_clk), .reset_n(reset_n), .adcI(adcI),
    .adcQ(adcQ), .adcValid(adcValid), .headerLastBit(headerLastBit),
    .packetEnd(packetEnd), .rateHigh(rateHigh), .trainValid(trainValid),
    .trainIci(trainIci), .trainIsi(trainIsi), .eqIciDisable(eqIciDisable),
    .eqIsiDisable(eqIsiDisable), .lockTrackEnable(lockTrackEnable),
    .svcLockLocal(svcLockLocal), .rxSvcLock(rxSvcLock), .rxBit(rxBit),
    .rxBitValid(rxBitValid), .timingAdjust(timingAdjust));
  ////////////////////////////////////////////////////////////////////////////
  // watchers: bit pulses counted, interpolator range kept sticky
  always @(posedge sys_clk) begin
    if (rxBitValid === 1'b1)
      bitCount <= bitCount + 16'h0001;
    if ((timingAdjust >= -TIMING_LIMIT && timingAdjust <= TIMING_LIMIT)
        !== 1'b1)
      rangeBad <= 1'b1;
  end
  // descrambler reference fed by the bits that enter it inside the top;
  // each released bit shows on rxBit two edges after it went in
  always @(posedge sys_clk) begin
    expHist <= {expHist[0], (dut.descrambler.inValid === 1'b1)
      & (dut.descrambler.inBit ^ refSr[TAP_A-1] ^ refSr[TAP_B-1])};
    if (dut.descrambler.inValid === 1'b1)
      refSr <= {refSr[5:0], dut.descrambler.inBit};
    if (dut.descrambler.clear === 1'b1)
      refSr <= 7'h00;
    if (rxBitValid === 1'b1) begin
      descChecked++;
      checkVal({15'h0000, rxBit}, {15'h0000, expHist[1]});
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("counts: compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : checkVal
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    tick();
    sig = 1'b0;
  endtask : pulse
  // one symbol burst, then enough quiet time for correlation and shifting
  task automatic sendSym;
    int n;
    pulse(symStart);
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      tick();
      n++;
    end
    if (n == 40) begin
      errors++;
      summarize();
    end
    repeat (120) tick();
  endtask : sendSym
  task automatic runPacket(input logic [15:0] bps);
    logic [15:0] base;
    base = bitCount;
    pulse(headerLastBit);
    repeat (7) sendSym();
    checkVal(bitCount - base, 16'h0000);
    repeat (3) begin
      base = bitCount;
      sendSym();
      checkVal(bitCount - base, bps);
    end
    checkVal({15'h0000, rangeBad}, 16'h0000);
    pulse(packetEnd);
    tick();
  endtask : runPacket
  ////////////////////////////////////////////////////////////////////////////
  // no header seen: samples never turn into bits
  task automatic test_silent;
    logic [15:0] base;
    logic [7:0] held;
    base = bitCount;
    held = timingAdjust;
    checkVal({14'h0000, rxBit, rxBitValid}, 16'h0000);
    repeat (2) sendSym();
    checkVal(bitCount - base, 16'h0000);
    checkVal({8'h00, timingAdjust}, {8'h00, held});
    $display("test silent done");
  endtask : test_silent
  task automatic test_top;
    trainIci = 4'h3;
    trainIsi = 4'h2;
    pulse(trainValid);
    trainIci = 4'hF;
    rateHigh = 1'b1;
    runPacket(16'h0008);
    $display("test top done");
  endtask : test_top
  task automatic test_low;
    rateHigh = 1'b0;
    eqIciDisable = 1'b1;
    eqIsiDisable = 1'b1;
    runPacket(16'h0004);
    eqIciDisable = 1'b0;
    eqIsiDisable = 1'b0;
    $display("test low done");
  endtask : test_low
  task automatic test_locked;
    rateHigh = 1'b1;
    lockTrackEnable = 1'b1;
    svcLockLocal = 1'b1;
    rxSvcLock = 1'b1;
    runPacket(16'h0008);
    rxSvcLock = 1'b0;
    runPacket(16'h0008);
    $display("test locked done");
  endtask : test_locked
  // descrambler through the top: the watcher judges every released bit
  task automatic test_desc;
    int base;
    base = descChecked;
    rateHigh = 1'b1;
    runPacket(16'h0008);
    checkVal(16'(descChecked - base), 16'h0018);
    $display("test desc done");
  endtask : test_desc
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    tick();
    checkVal({8'h00, timingAdjust}, 16'h0000);
    test_silent();
    test_top();
    test_low();
    test_locked();
    test_silent();
    test_desc();
    summarize();
  end
endmodule : test_dsss_cck_demod_tracking
